// [odc_map.svh]
/*
 * Offsets, field positions, reset values and timing figures for the output
 * page configuration bank of outputs 0B and 1B.
 * Assumes inclusion by bare name from the package and the bank module.
 */
`ifndef ODC_MAP_SVH
`define ODC_MAP_SVH

// page number that the output page answers to; arbitrary value
`define ODC_OUT_PAGE 8'h01
`define ODC_PAGE_ADDR 8'hff
`define ODC_PAGE_RESET 8'h00

`define ODC_OFS_OUT0B_DRV_STD 8'h65
`define ODC_OFS_OUT0B_TERM 8'h66
`define ODC_OFS_OUT0B_DIVTOP 8'h67
`define ODC_OFS_OUT1B_DIVHI 8'h68
`define ODC_OFS_OUT1B_DIVMID 8'h69
`define ODC_OFS_OUT1B_DIVLO 8'h6a
`define ODC_OFS_OUT1B_PHASE 8'h6b
`define ODC_REG_RESET 8'h00

`define ODC_DRV_STD_MSB 2
`define ODC_DIVTOP_MSB 7
`define ODC_DIVTOP_LSB 6
`define ODC_FINE_TOP_BIT 4
`define ODC_MODE_MSB 3
`define ODC_DIV1B_HI_MSB 3
`define ODC_PHASE_MSB 7
`define ODC_PHASE_LSB 6
`define ODC_STRENGTH_MSB 2

`define ODC_FINE_STEP_PS 8'd30
`define ODC_FINE_MAX_STEPS 3'd4
`define ODC_DIV_MIN 26'd2

`endif

// [odc_pkg.sv]
/*
 * Types for the output page configuration bank: decoded driver standards,
 * output modes and the bank's packed state.
 * Assumes odc_map.svh is reachable by bare name.
 */
package odc_pkg;
`include "odc_map.svh"

	typedef enum logic [2:0] {
		DRV_LVDS,
		DRV_LVPECL_CM,
		DRV_CML_DC,
		DRV_HCSL_DC,
		DRV_LVDS_BOOST,
		DRV_LVPECL_NOCM,
		DRV_RESERVED
	} odc_drv_std_t;

	typedef enum logic [2:0] {
		MODE_DIFF_EXT_TERM,
		MODE_DIFF_PULLUP,
		MODE_DIFF_PULLDOWN,
		MODE_CMOS_POS,
		MODE_CMOS_NEG,
		MODE_CMOS_BOTH,
		MODE_RESERVED
	} odc_mode_t;

	typedef struct packed {
		logic [7:0] page;
		logic [7:0] drvStd0b;
		logic [7:0] term0b;
		logic [7:0] divTop0b;
		logic [7:0] divHi1b;
		logic [7:0] divMid1b;
		logic [7:0] divLo1b;
		logic [7:0] phase1b;
		logic [7:0] rdData;
		logic rdValid;
		logic [25:0] cnt0b;
		logic [25:0] cnt1b;
		logic clk0b;
		logic clk1b;
		logic posPin0b;
		logic negPin0b;
		logic posPin1b;
		logic negPin1b;
	} odc_state_t;
endpackage

// [odc_output_divider_driver_config.sv]
/*
 * Output page configuration bank for clock outputs 0B and 1B: paged register
 * file, field decode, two output dividers and CMOS pin routing.
 * Assumes the register port is driven synchronously to clk by the host port
 * logic, and that the 0B divider low bits and 0B fine delay low bits come
 * from neighbouring registers held elsewhere on the same clock.
 */
// Notes on behaviour
// - driver standard code 0..5 decodes to LVDS, LVPECL, CML, HCSL, boosted LVDS, LVPECL2
// - 0B divider bits 25:24 live in bits 7:6 at 67h
// - fine delay is three-bit code times 30 ps, capped at four steps
// - mode 0000 gives differential output with external termination
// - mode 0010 selects internal pull-up, 0001 internal pull-down, both differential
// - CMOS modes: 0100 positive pin, 1000 negative pin, 1100 both pins
// - 1B divider assembled from 68h low nibble, 69h and 6Ah
// - two-bit phase select routes true or inverted phase onto CMOS pins
// - register FFh on every page is read-write and selects the page
`include "odc_map.svh"
module odc_output_divider_driver_config
(
	input wire logic clk,
	input wire logic srst,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	output logic regRdValid,
	output logic [7:0] activePage,
	input wire logic [23:0] div0bLow,
	input wire logic [1:0] fineDelay0bLow,
	output odc_pkg::odc_drv_std_t driverStandardSel,
	output odc_pkg::odc_mode_t outputMode0b,
	output logic [2:0] outputDelayCode,
	output logic [7:0] fineDelayPs,
	output logic [25:0] outputDividerValue0b,
	output logic [19:0] outputDividerValue1b,
	output logic [1:0] phaseSel1b,
	output logic [2:0] seStrength1b,
	output logic positiveOutputPin0b,
	output logic negativeOutputPin0b,
	output logic positiveOutputPin1b,
	output logic negativeOutputPin1b
);
	import odc_pkg::*;

	odc_state_t state_reg;
	odc_state_t state_next;
	logic onOutPage;
	logic [25:0] div1bWide;

	function automatic logic [25:0] divStep(input logic [25:0] cnt, input logic [25:0] div);
		if (div < `ODC_DIV_MIN)
			return 26'd0;
		else if (cnt >= div - 26'd1)
			return 26'd0;
		else
			return cnt + 26'd1;
	endfunction

	// high for the first half of each period; below two the divider is held off
	function automatic logic divLevel(input logic [25:0] cnt, input logic [25:0] div);
		return (div >= `ODC_DIV_MIN) && (cnt < (div >> 1));
	endfunction

	function automatic logic [7:0] fineDelay(input logic [2:0] code);
		logic [2:0] steps;
		steps = (code > `ODC_FINE_MAX_STEPS) ? `ODC_FINE_MAX_STEPS : code;
		return {5'h00, steps} * `ODC_FINE_STEP_PS;
	endfunction

	function automatic logic [7:0] regRead(input odc_state_t s, input logic [7:0] addr);
		logic [7:0] v;
		v = 8'h00;
		if (addr == `ODC_PAGE_ADDR)
			v = s.page;
		else if (s.page == `ODC_OUT_PAGE)
		begin
			case (addr)
				`ODC_OFS_OUT0B_DRV_STD: v = s.drvStd0b;
				`ODC_OFS_OUT0B_TERM: v = s.term0b;
				`ODC_OFS_OUT0B_DIVTOP: v = s.divTop0b;
				`ODC_OFS_OUT1B_DIVHI: v = s.divHi1b;
				`ODC_OFS_OUT1B_DIVMID: v = s.divMid1b;
				`ODC_OFS_OUT1B_DIVLO: v = s.divLo1b;
				`ODC_OFS_OUT1B_PHASE: v = s.phase1b;
				default: v = 8'h00;
			endcase
		end
		return v;
	endfunction

	assign onOutPage = (state_reg.page == `ODC_OUT_PAGE);

	always_comb
	begin
		case (state_reg.drvStd0b[`ODC_DRV_STD_MSB:0])
			3'h0: driverStandardSel = DRV_LVDS;
			3'h1: driverStandardSel = DRV_LVPECL_CM;
			3'h2: driverStandardSel = DRV_CML_DC;
			3'h3: driverStandardSel = DRV_HCSL_DC;
			3'h4: driverStandardSel = DRV_LVDS_BOOST;
			3'h5: driverStandardSel = DRV_LVPECL_NOCM;
			default: driverStandardSel = DRV_RESERVED;
		endcase
		case (state_reg.term0b[`ODC_MODE_MSB:0])
			4'h0: outputMode0b = MODE_DIFF_EXT_TERM;
			4'h2: outputMode0b = MODE_DIFF_PULLUP;
			4'h1: outputMode0b = MODE_DIFF_PULLDOWN;
			4'h4: outputMode0b = MODE_CMOS_POS;
			4'h8: outputMode0b = MODE_CMOS_NEG;
			4'hc: outputMode0b = MODE_CMOS_BOTH;
			default: outputMode0b = MODE_RESERVED;
		endcase
	end

	// fine code bits 1:0 sit in the coarse delay register kept outside this bank
	assign outputDelayCode = {state_reg.divTop0b[`ODC_FINE_TOP_BIT], fineDelay0bLow};
	assign fineDelayPs = fineDelay(outputDelayCode);
	assign outputDividerValue0b = {state_reg.divTop0b[`ODC_DIVTOP_MSB:`ODC_DIVTOP_LSB],
		div0bLow};
	assign outputDividerValue1b = {state_reg.divHi1b[`ODC_DIV1B_HI_MSB:0], state_reg.divMid1b,
		state_reg.divLo1b};
	assign div1bWide = {6'h00, outputDividerValue1b};
	assign phaseSel1b = state_reg.phase1b[`ODC_PHASE_MSB:`ODC_PHASE_LSB];
	// strength is only stored; software is expected to write all ones
	assign seStrength1b = state_reg.phase1b[`ODC_STRENGTH_MSB:0];
	assign regRdData = state_reg.rdData;
	assign regRdValid = state_reg.rdValid;
	assign activePage = state_reg.page;
	assign positiveOutputPin0b = state_reg.posPin0b;
	assign negativeOutputPin0b = state_reg.negPin0b;
	assign positiveOutputPin1b = state_reg.posPin1b;
	assign negativeOutputPin1b = state_reg.negPin1b;

	always_comb
	begin
		state_next = state_reg;
		state_next.rdValid = regRdEn;
		state_next.rdData = regRdEn ? regRead(state_reg, regAddr) : 8'h00;
		if (regWrEn)
		begin
			if (regAddr == `ODC_PAGE_ADDR)
				state_next.page = regWrData;
			else if (onOutPage)
			begin
				case (regAddr)
					`ODC_OFS_OUT0B_DRV_STD: state_next.drvStd0b = regWrData;
					`ODC_OFS_OUT0B_TERM: state_next.term0b = regWrData;
					`ODC_OFS_OUT0B_DIVTOP: state_next.divTop0b = regWrData;
					`ODC_OFS_OUT1B_DIVHI: state_next.divHi1b = regWrData;
					`ODC_OFS_OUT1B_DIVMID: state_next.divMid1b = regWrData;
					`ODC_OFS_OUT1B_DIVLO: state_next.divLo1b = regWrData;
					`ODC_OFS_OUT1B_PHASE: state_next.phase1b = regWrData;
					default: state_next.page = state_reg.page;
				endcase
			end
		end
		state_next.cnt0b = divStep(state_reg.cnt0b, outputDividerValue0b);
		state_next.cnt1b = divStep(state_reg.cnt1b, div1bWide);
		state_next.clk0b = divLevel(state_next.cnt0b, outputDividerValue0b);
		state_next.clk1b = divLevel(state_next.cnt1b, div1bWide);
		// 0B pins: differential modes and CMOS both-pins mode drive true and inverted, single-pin CMOS modes gate a pin
		case (outputMode0b)
			MODE_DIFF_EXT_TERM, MODE_DIFF_PULLUP, MODE_DIFF_PULLDOWN:
			begin
				state_next.posPin0b = state_reg.clk0b;
				state_next.negPin0b = ~state_reg.clk0b;
			end
			MODE_CMOS_POS:
			begin
				state_next.posPin0b = state_reg.clk0b;
				state_next.negPin0b = 1'b0;
			end
			MODE_CMOS_NEG:
			begin
				state_next.posPin0b = 1'b0;
				state_next.negPin0b = ~state_reg.clk0b;
			end
			MODE_CMOS_BOTH:
			begin
				state_next.posPin0b = state_reg.clk0b;
				state_next.negPin0b = ~state_reg.clk0b;
			end
			default:
			begin
				state_next.posPin0b = 1'b0;
				state_next.negPin0b = 1'b0;
			end
		endcase
		case (phaseSel1b)
			2'b00:
			begin
				state_next.posPin1b = state_reg.clk1b;
				state_next.negPin1b = ~state_reg.clk1b;
			end
			2'b01:
			begin
				state_next.posPin1b = state_reg.clk1b;
				state_next.negPin1b = state_reg.clk1b;
			end
			default:
			begin
				state_next.posPin1b = ~state_reg.clk1b;
				state_next.negPin1b = ~state_reg.clk1b;
			end
		endcase
		if (srst)
			state_next = '0;
	end

	always_ff @(posedge clk)
		state_reg <= state_next;

	sequence s_pageWrite;
		regWrEn && regAddr == `ODC_PAGE_ADDR;
	endsequence

	sequence s_outWrite(logic [7:0] ofs);
		regWrEn && onOutPage && regAddr == ofs;
	endsequence

	property p_drvDecode;
		@(posedge clk) disable iff (srst)
		(state_reg.drvStd0b[2:0] inside {3'h2, 3'h5}) |->
			driverStandardSel == (state_reg.drvStd0b[2] ? DRV_LVPECL_NOCM : DRV_CML_DC);
	endproperty
	a_drvDecode: assert property (p_drvDecode) else $error("driver standard decode wrong");

	property p_divTop0b;
		@(posedge clk) disable iff (srst)
		s_outWrite(`ODC_OFS_OUT0B_DIVTOP) |=>
			outputDividerValue0b[25:24] == $past(regWrData[7:6]);
	endproperty
	a_divTop0b: assert property (p_divTop0b) else $error("0B divider top bits not stored");

	property p_fineDelay;
		@(posedge clk) disable iff (srst)
		(outputDelayCode >= 3'd4) |-> fineDelayPs == 8'd120;
	endproperty
	a_fineDelay: assert property (p_fineDelay) else $error("fine delay not capped at four steps");

	property p_extTerm;
		@(posedge clk) disable iff (srst)
		(state_reg.term0b[3:0] == 4'h0) |-> outputMode0b == MODE_DIFF_EXT_TERM
			##1 (outputMode0b != MODE_DIFF_EXT_TERM || negativeOutputPin0b != positiveOutputPin0b);
	endproperty
	a_extTerm: assert property (p_extTerm) else $error("external termination mode wrong");

	property p_pullSel;
		@(posedge clk) disable iff (srst)
		(state_reg.term0b[3:0] == 4'h1) |-> outputMode0b == MODE_DIFF_PULLDOWN;
	endproperty
	a_pullSel: assert property (p_pullSel) else $error("pull-down mode not selected");

	property p_cmosPos;
		@(posedge clk) disable iff (srst)
		(outputMode0b == MODE_CMOS_POS) ##1 (outputMode0b == MODE_CMOS_POS)
			|-> !negativeOutputPin0b;
	endproperty
	a_cmosPos: assert property (p_cmosPos) else $error("negative pin driven in positive-only mode");

	property p_div1b;
		@(posedge clk) disable iff (srst)
		s_outWrite(`ODC_OFS_OUT1B_DIVLO) |=> outputDividerValue1b[7:0] == $past(regWrData);
	endproperty
	a_div1b: assert property (p_div1b) else $error("1B divider low byte not stored");

	property p_phaseSame;
		@(posedge clk) disable iff (srst)
		(phaseSel1b == 2'b01) [*2] |-> positiveOutputPin1b == negativeOutputPin1b;
	endproperty
	a_phaseSame: assert property (p_phaseSame) else $error("phase select 01 pins differ");

	property p_pageWrite;
		@(posedge clk) disable iff (srst)
		s_pageWrite |=> activePage == $past(regWrData);
	endproperty
	a_pageWrite: assert property (p_pageWrite) else $error("page register not written");

	property p_resetClear;
		@(posedge clk)
		srst |=> outputDividerValue1b == 20'h00000 && activePage == 8'h00 && !regRdValid;
	endproperty
	a_resetClear: assert property (p_resetClear) else $error("state not cleared by reset");

	property p_readBack;
		@(posedge clk) disable iff (srst)
		(regRdEn && regAddr == `ODC_OFS_OUT1B_PHASE && onOutPage) |=>
			regRdValid && regRdData == $past(state_reg.phase1b);
	endproperty
	a_readBack: assert property (p_readBack) else $error("read back differs from stored");

	property p_divWrap;
		@(posedge clk) disable iff (srst)
		(div1bWide == 26'd4 && state_reg.cnt1b == 26'd3) [*1] ##0 $stable(div1bWide)
			|=> state_reg.cnt1b == 26'd0 || div1bWide != 26'd4;
	endproperty
	a_divWrap: assert property (p_divWrap) else $error("divider count did not wrap");

endmodule // odc_output_divider_driver_config

// [odc_output_divider_driver_config_bench.sv]
/*
 * Self-checking bench for the output page configuration bank: paging, read-back,
 * field decodes, divider rates and CMOS pin routing.
 * Assumes the bank alone on one 100 MHz clock, driven through its register strobes.
 */
module odc_output_divider_driver_config_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import odc_pkg::*;

	logic clk = 1'b0;
	logic srst = 1'b1;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic [23:0] div0bLow = 24'habcdef;
	logic [1:0] fineDelay0bLow = 2'h0;
	logic [7:0] regRdData;
	logic regRdValid;
	logic [7:0] activePage;
	odc_drv_std_t driverStandardSel;
	odc_mode_t outputMode0b;
	logic [2:0] outputDelayCode;
	logic [7:0] fineDelayPs;
	logic [25:0] outputDividerValue0b;
	logic [19:0] outputDividerValue1b;
	logic [1:0] phaseSel1b;
	logic [2:0] seStrength1b;
	logic pos0b, neg0b, pos1b, neg1b;
	int badCount = 0;
	int totalChecks = 0;
	int rises [4];
	int same1b;

	always #5 clk = ~clk;

	odc_output_divider_driver_config odc_output_divider_driver_config_i (
		.clk(clk), .srst(srst), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .activePage(activePage), .div0bLow(div0bLow),
		.fineDelay0bLow(fineDelay0bLow), .driverStandardSel(driverStandardSel),
		.outputMode0b(outputMode0b), .outputDelayCode(outputDelayCode),
		.fineDelayPs(fineDelayPs), .outputDividerValue0b(outputDividerValue0b),
		.outputDividerValue1b(outputDividerValue1b), .phaseSel1b(phaseSel1b),
		.seStrength1b(seStrength1b), .positiveOutputPin0b(pos0b),
		.negativeOutputPin0b(neg0b), .positiveOutputPin1b(pos1b),
		.negativeOutputPin1b(neg1b)
	);

	task automatic printVerdict();
		if (badCount == 0 && totalChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [25:0] got, input logic [25:0] exp, input string what);
		totalChecks++;
		if (got !== exp)
		begin
			badCount++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(posedge clk);
		#1;
		regWrEn = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		#1;
		regRdEn = 1'b1;
		regAddr = a;
		@(posedge clk);
		#1;
		regRdEn = 1'b0;
		chk(26'(regRdValid), 26'd1, "read valid");
		chk(26'(regRdData), 26'(exp), "read data");
	endtask

	// settle first: a new divider value may land mid-count
	task automatic measure(input int n);
		logic [3:0] prev;
		logic [3:0] cur;
		rises = '{default: 0};
		same1b = 0;
		repeat (8) @(posedge clk);
		#1;
		prev = {pos0b, neg0b, pos1b, neg1b};
		repeat (n)
		begin
			@(posedge clk);
			#1;
			cur = {pos0b, neg0b, pos1b, neg1b};
			for (int i = 0; i < 4; i++)
				if (cur[i] && !prev[i])
					rises[i]++;
			if (cur[1] == cur[0])
				same1b++;
			prev = cur;
		end
	endtask

	logic [3:0] modeCode [7] = '{4'h0, 4'h2, 4'h1, 4'h4, 4'h8, 4'hc, 4'h3};
	odc_mode_t modeExp [7] = '{MODE_DIFF_EXT_TERM, MODE_DIFF_PULLUP, MODE_DIFF_PULLDOWN,
		MODE_CMOS_POS, MODE_CMOS_NEG, MODE_CMOS_BOTH, MODE_RESERVED};

	initial
	begin
		repeat (12) @(posedge clk);
		#1;
		srst = 1'b0;
		rd(8'hff, 8'h00);
		wr(8'h69, 8'h5a);
		rd(8'h69, 8'h00);
		wr(8'hff, 8'h01);
		chk(26'(activePage), 26'h01, "page");
		rd(8'hff, 8'h01);
		for (int a = 8'h65; a <= 8'h6b; a++)
			rd(8'(a), 8'h00);
		for (int a = 8'h65; a <= 8'h6b; a++)
			wr(8'(a), 8'(a) ^ 8'h3c);
		for (int a = 8'h65; a <= 8'h6b; a++)
			rd(8'(a), 8'(a) ^ 8'h3c);
		@(posedge clk);
		#1;
		chk(26'(regRdValid), 26'd0, "valid stands one cycle");
		wr(8'h70, 8'h77);
		rd(8'h70, 8'h00);
		chk(26'(outputDividerValue1b), 26'h45556, "1b divider");
		chk(outputDividerValue0b, {2'b01, 24'habcdef}, "0b divider");
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h65, 8'(c));
			chk(26'(driverStandardSel), 26'((c < 6) ? c : 6), "driver standard");
		end
		for (int c = 0; c < 8; c++)
		begin
			fineDelay0bLow = 2'(c);
			wr(8'h67, {3'b000, 1'(c >> 2), 4'h0});
			chk(26'(outputDelayCode), 26'(c), "delay code");
			chk(26'(fineDelayPs), 26'(((c > 4) ? 4 : c) * 30), "delay ps");
		end
		for (int i = 0; i < 7; i++)
		begin
			wr(8'h66, {4'h0, modeCode[i]});
			chk(26'(outputMode0b), 26'(modeExp[i]), "mode");
		end
		div0bLow = 24'd6;
		wr(8'h67, 8'h00);
		wr(8'h66, 8'h00);
		wr(8'h68, 8'h00);
		wr(8'h69, 8'h00);
		wr(8'h6b, 8'h07);
		// ascending values so for n = 3 and 4 the running count never exceeds the new limit
		for (int n = 2; n <= 4; n++)
		begin
			wr(8'h6a, 8'(n));
			measure(60);
			chk(26'(rises[1]), 26'(60 / n), "1b rate");
			chk(26'(same1b), 26'd0, "1b true and inverted");
		end
		chk(26'(rises[3]), 26'd10, "0b rate");
		chk(26'(rises[2]), 26'd10, "0b inverted pin rate");
		for (int p = 1; p < 4; p++)
		begin
			wr(8'h6b, {2'(p), 6'h07});
			measure(40);
			chk(26'(same1b), 26'd40, "1b same phase");
			chk(26'(rises[1]), 26'd10, "1b rate with phase");
			chk(26'(phaseSel1b), 26'(p), "phase select field");
			chk(26'(seStrength1b), 26'd7, "strength field");
		end
		for (int i = 3; i < 6; i++)
		begin
			wr(8'h66, {4'h0, modeCode[i]});
			measure(60);
			chk(26'(rises[3]), (i == 4) ? 26'd0 : 26'd10, "cmos pos pin");
			chk(26'(rises[2]), (i == 3) ? 26'd0 : 26'd10, "cmos neg pin");
		end
		srst = 1'b1;
		@(posedge clk);
		#1;
		srst = 1'b0;
		rd(8'hff, 8'h00);
		printVerdict();
	end

	initial
	begin
		#100us;
		badCount++;
		printVerdict();
	end
endmodule // odc_output_divider_driver_config_bench
